// >>> verilog/ssp_top.v
// Serial port unit: register slave, bit clock, framing, two lanes, companding, streams
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "ssp_map.vh"

module ssp_top #(
    parameter PORT_ID = 0 // Port position 0..3, fixes its TDM role
) (
    input wire i_mclk, // Core clock, 40 MHz
    input wire i_srst, // Synchronous reset, active high
    input wire [3:0] i_avs_address, // Byte address
    input wire i_avs_read, // Read request
    input wire i_avs_write, // Write request
    input wire [31:0] i_avs_writedata, // Write data
    input wire [3:0] i_avs_byteenable, // Byte lanes
    output wire [31:0] o_avs_readdata, // Read data
    output wire o_avs_waitrequest, // Stall
    input wire i_sclk, // Bit clock pin level
    output wire o_sclk, // Bit clock drive value
    output wire o_sclk_oe, // Bit clock drive enable
    input wire i_fs, // Frame sync pin level
    output wire o_fs, // Frame sync drive value
    output wire o_fs_oe, // Frame sync drive enable
    input wire [1:0] i_dat, // Lane pin levels
    output wire [1:0] o_dat, // Lane drive values
    output wire [1:0] o_dat_oe, // Lane drive enables
    input wire [31:0] i_tx_data, // Transmit stream word
    input wire i_tx_valid, // Transmit word offered
    output wire o_tx_ready, // Transmit buffer has room
    output wire [31:0] o_rx_data, // Receive stream word
    output wire o_rx_valid, // Receive word offered
    input wire i_rx_ready, // Receive word taken
    output wire o_frame_start // Frame start pulse for the paired port
);
    localparam [0:0] TDM_TX_SIDE = (PORT_ID >= 2) ? 1'b1 : 1'b0;

    // ----------------------------------------------------------------
    // Companding
    // ----------------------------------------------------------------
    function [7:0] ssp_mu_enc;
        input [15:0] s;
        reg [15:0] mag;
        reg [15:0] man;
        reg [2:0] seg;
        integer k;
        begin
            mag = s[15] ? (~s + 16'h0001) : s;
            mag = {2'b00, mag[15:2]};
            if (mag > `SSP_MU_CLIP) begin
                mag = `SSP_MU_CLIP;
            end
            mag = mag + `SSP_MU_BIAS;
            seg = 3'h0;
            for (k = 0; k < 8; k = k + 1) begin
                if (mag[k + 5]) begin
                    seg = k[2:0];
                end
            end
            man = mag >> ({1'b0, seg} + 4'h1);
            ssp_mu_enc = ~{s[15], seg, man[3:0]};
        end
    endfunction

    function [7:0] ssp_a_enc;
        input [15:0] s;
        reg [15:0] mag;
        reg [15:0] man;
        reg [2:0] seg;
        integer k;
        integer t;
        begin
            mag = s[15] ? (~s + 16'h0001) : s;
            mag = {3'b000, mag[15:3]};
            if (mag > `SSP_A_CLIP) begin
                mag = `SSP_A_CLIP;
            end
            seg = 3'h0;
            for (k = 5; k < 12; k = k + 1) begin
                t = k - 4;
                if (mag[k]) begin
                    seg = t[2:0];
                end
            end
            man = mag >> ((seg == 3'h0) ? 3'h1 : seg);
            ssp_a_enc = {~s[15], seg, man[3:0]} ^ `SSP_A_XOR;
        end
    endfunction

    function [15:0] ssp_mu_dec;
        input [7:0] c;
        reg [7:0] u;
        reg [15:0] t;
        begin
            u = ~c;
            t = ({9'h000, u[3:0], 3'h0} + `SSP_MU_DBIAS) << u[6:4];
            ssp_mu_dec = u[7] ? (`SSP_MU_DBIAS - t) : (t - `SSP_MU_DBIAS);
        end
    endfunction

    function [15:0] ssp_a_dec;
        input [7:0] c;
        reg [7:0] a;
        reg [15:0] t;
        begin
            a = c ^ `SSP_A_XOR;
            t = {8'h00, a[3:0], 4'h8};
            if (a[6:4] != 3'h0) begin
                t = t + 16'h0100;
            end
            if (a[6:4] > 3'h1) begin
                t = t << (a[6:4] - 3'h1);
            end
            ssp_a_dec = a[7] ? t : (~t + 16'h0001);
        end
    endfunction

    // ----------------------------------------------------------------
    // Registers and bus slave
    // ----------------------------------------------------------------
    reg [31:0] ctrl_reg;
    reg [15:0] div_reg;
    reg [4:0] slots_reg;
    reg ovf_reg;
    reg unf_reg;
    reg ack_reg;
    reg [31:0] rdata_reg;
    reg active_reg;
    reg first_reg;
    reg [5:0] bit_cnt_reg;
    reg [4:0] slot_reg;
    reg fs_prev_reg;
    reg fs_out_reg;
    reg start_pulse_reg;
    reg [15:0] div_cnt_reg;
    reg isclk_reg;
    reg sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
    reg fs_s1_reg, fs_s2_reg;
    reg [1:0] dat_s1_reg, dat_s2_reg;
    reg [1:0] ld_pend_reg;
    reg [1:0] push_pend_reg;
    reg [31:0] rd_mux;
    reg [31:0] wmask;
    wire [31:0] tx_rd_data;
    wire tx_rd_valid;
    wire rx_wr_ready;
    wire [63:0] rxb_w;

    wire req = i_avs_read | i_avs_write;
    wire take = req & ack_reg;
    wire wr_ctrl = take & i_avs_write & (i_avs_address == `SSP_REG_CTRL);
    wire wr_div = take & i_avs_write & (i_avs_address == `SSP_REG_CLKDIV);
    wire wr_st = take & i_avs_write & (i_avs_address == `SSP_REG_STATUS);
    wire wr_tdm = take & i_avs_write & (i_avs_address == `SSP_REG_TDM);

    // Every access waits exactly one cycle, so read data is always registered
    assign o_avs_waitrequest = req & ~ack_reg;
    assign o_avs_readdata = rdata_reg;

    wire en = ctrl_reg[`SSP_CTL_EN];
    wire lsbf = ctrl_reg[`SSP_CTL_LSBF];
    wire iclk = ctrl_reg[`SSP_CTL_ICLK];
    wire ifs = ctrl_reg[`SSP_CTL_IFS];
    wire [1:0] mode = ctrl_reg[`SSP_CTL_MODE_HI:`SSP_CTL_MODE_LO];
    wire [1:0] cmp = ctrl_reg[`SSP_CTL_CMP_HI:`SSP_CTL_CMP_LO];
    wire is_i2s = (mode == `SSP_MODE_I2S);
    wire is_tdm = (mode == `SSP_MODE_TDM);
    wire [5:0] wl_raw = {1'b0, ctrl_reg[`SSP_CTL_WLEN_HI:`SSP_CTL_WLEN_LO]} + 6'h01;
    wire [5:0] wl_min = is_i2s ? `SSP_WLEN_MIN_I2S : `SSP_WLEN_MIN_STD;
    wire [5:0] wlen = (wl_raw < wl_min) ? wl_min : wl_raw;
    wire [5:0] wlast = wlen - 6'h01;
    wire [5:0] pad = `SSP_WLEN_FULL - wlen;
    // Lane directions are free outside TDM; TDM fixes the side by port position
    wire [1:0] lane_tx = is_tdm ? {2{TDM_TX_SIDE}} :
        {ctrl_reg[`SSP_CTL_DIRB], ctrl_reg[`SSP_CTL_DIRA]};

    always @* begin
        wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
            {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
        case (i_avs_address)
            `SSP_REG_CTRL: rd_mux = ctrl_reg;
            `SSP_REG_CLKDIV: rd_mux = {16'h0000, div_reg};
            `SSP_REG_STATUS: rd_mux = {27'h0000000, active_reg, ~o_tx_ready, o_rx_valid,
                unf_reg, ovf_reg};
            `SSP_REG_TDM: rd_mux = {27'h0000000, slots_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and bit clock
    // ----------------------------------------------------------------
    wire [31:0] min_half_w = `SSP_SCLK_MIN_HALF_CYC;
    wire [15:0] half = (div_reg < min_half_w[15:0]) ? min_half_w[15:0] : div_reg;
    wire tick = en & iclk & (div_cnt_reg >= half - 16'h0001);
    wire rise_evt = iclk ? (tick & ~isclk_reg) : (en & sclk_s2_reg & ~sclk_s3_reg);
    wire fall_evt = iclk ? (tick & isclk_reg) : (en & ~sclk_s2_reg & sclk_s3_reg);
    wire fs_in = ifs ? fs_out_reg : fs_s2_reg;
    // I2S sync is a word select level, so any change starts a word
    wire start_det = rise_evt & (is_i2s ? (fs_in ^ fs_prev_reg) : fs_in);
    wire last_bit = active_reg & ~first_reg & (bit_cnt_reg == wlast);
    wire done_w = rise_evt & last_bit;
    wire cont_w = done_w & is_tdm & (slot_reg != slots_reg) & ~start_det;
    wire begin_w = start_det | cont_w;
    wire first_fall = fall_evt & first_reg & active_reg;
    wire fs_cond = ~active_reg | ((is_i2s | ~is_tdm | (slot_reg == slots_reg)) &
        ~first_reg & (bit_cnt_reg == wlast));
    wire pop = tx_rd_valid & (|ld_pend_reg) & ~first_fall;
    wire ld_sel = ~ld_pend_reg[0];
    wire ps_sel = ~push_pend_reg[0];
    wire push_ok = rx_wr_ready & (|push_pend_reg);
    wire unf_set = first_fall & (|ld_pend_reg);
    wire ovf_set = done_w & (|push_pend_reg);
    wire [31:0] tx_cooked = (cmp == `SSP_CMP_MU) ? {24'h000000, ssp_mu_enc(tx_rd_data[15:0])} :
        (cmp == `SSP_CMP_A) ? {24'h000000, ssp_a_enc(tx_rd_data[15:0])} : tx_rd_data;

    assign o_sclk = isclk_reg;
    assign o_sclk_oe = en & iclk;
    assign o_fs = fs_out_reg;
    assign o_fs_oe = en & ifs;
    assign o_frame_start = start_pulse_reg;

    always @(posedge i_mclk) begin
        if (i_srst) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
            fs_s1_reg <= 1'b0;
            fs_s2_reg <= 1'b0;
            dat_s1_reg <= 2'h0;
            dat_s2_reg <= 2'h0;
        end else begin
            sclk_s1_reg <= i_sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            fs_s1_reg <= i_fs;
            fs_s2_reg <= fs_s1_reg;
            dat_s1_reg <= i_dat;
            dat_s2_reg <= dat_s1_reg;
        end
    end

    always @(posedge i_mclk) begin
        if (i_srst | ~(en & iclk)) begin
            div_cnt_reg <= 16'h0000;
            isclk_reg <= 1'b0;
        end else if (tick) begin
            div_cnt_reg <= 16'h0000;
            isclk_reg <= ~isclk_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    always @(posedge i_mclk) begin
        if (i_srst) begin
            ctrl_reg <= `SSP_CTRL_RST;
            div_reg <= `SSP_CLKDIV_RST;
            slots_reg <= `SSP_TDM_RST;
            ovf_reg <= 1'b0;
            unf_reg <= 1'b0;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (req & ~ack_reg & i_avs_read) begin
                rdata_reg <= rd_mux;
            end
            if (wr_ctrl) begin
                ctrl_reg <= (ctrl_reg & ~wmask) | (i_avs_writedata & wmask);
            end
            if (wr_div) begin
                div_reg <= (div_reg & ~wmask[15:0]) | (i_avs_writedata[15:0] & wmask[15:0]);
            end
            if (wr_tdm & i_avs_byteenable[0]) begin
                slots_reg <= i_avs_writedata[4:0];
            end
            // A new event in the clearing cycle survives the clear
            ovf_reg <= ovf_set | (ovf_reg & ~(wr_st & i_avs_byteenable[0] &
                i_avs_writedata[`SSP_ST_OVF]));
            unf_reg <= unf_set | (unf_reg & ~(wr_st & i_avs_byteenable[0] &
                i_avs_writedata[`SSP_ST_UNF]));
        end
    end

    // ----------------------------------------------------------------
    // Framing sequencer
    // ----------------------------------------------------------------
    always @(posedge i_mclk) begin
        if (i_srst | ~en) begin
            active_reg <= 1'b0;
            first_reg <= 1'b0;
            bit_cnt_reg <= 6'h00;
            slot_reg <= 5'h00;
            fs_prev_reg <= 1'b0;
            fs_out_reg <= 1'b0;
            start_pulse_reg <= 1'b0;
        end else begin
            start_pulse_reg <= start_det;
            if (rise_evt) begin
                fs_prev_reg <= fs_in;
            end
            if (rise_evt & active_reg & ~first_reg) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
                if (last_bit) begin
                    active_reg <= 1'b0;
                end
            end
            if (cont_w) begin
                active_reg <= 1'b1;
                first_reg <= 1'b1;
                bit_cnt_reg <= 6'h00;
                slot_reg <= slot_reg + 5'h01;
            end
            if (start_det) begin
                active_reg <= 1'b1;
                first_reg <= 1'b1;
                bit_cnt_reg <= 6'h00;
                slot_reg <= 5'h00;
            end
            if (first_fall) begin
                first_reg <= 1'b0;
            end
            // Internal sync leads the first data bit by one bit time
            if (fall_evt & ifs & fs_cond) begin
                fs_out_reg <= is_i2s ? ~fs_out_reg : 1'b1;
            end else if (fall_evt & ifs & ~is_i2s) begin
                fs_out_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Stream sequencers: tx loads and rx pushes, one lane per cycle
    // ----------------------------------------------------------------
    always @(posedge i_mclk) begin
        if (i_srst | ~en) begin
            ld_pend_reg <= 2'h0;
            push_pend_reg <= 2'h0;
        end else begin
            if (begin_w) begin
                ld_pend_reg <= lane_tx;
            end else if (first_fall) begin
                ld_pend_reg <= 2'h0;
            end else if (pop) begin
                ld_pend_reg <= ld_pend_reg & (ld_sel ? 2'h1 : 2'h2);
            end
            // Unpushed words are dropped and flagged when the next word lands
            if (done_w) begin
                push_pend_reg <= ~lane_tx;
            end else if (push_ok) begin
                push_pend_reg <= push_pend_reg & (ps_sel ? 2'h1 : 2'h2);
            end
        end
    end

    // ----------------------------------------------------------------
    // Lanes
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : lane
            localparam [0:0] LANE = (g == 1) ? 1'b1 : 1'b0;
            reg [31:0] sh_reg;
            reg [31:0] txb_reg;
            reg [31:0] rxb_reg;
            reg dat_reg;
            wire rbit = dat_s2_reg[g];
            wire [31:0] tx_al = lsbf ? txb_reg : (txb_reg << pad);
            wire [31:0] rx_new = lsbf ? ({rbit, sh_reg[31:1]} >> pad) :
                ({sh_reg[30:0], rbit} & (32'hFFFF_FFFF >> pad));
            wire [15:0] rx_exp = (cmp == `SSP_CMP_MU) ? ssp_mu_dec(rx_new[7:0]) :
                ssp_a_dec(rx_new[7:0]);
            wire [31:0] rx_word = (cmp == `SSP_CMP_MU || cmp == `SSP_CMP_A) ?
                {{16{rx_exp[15]}}, rx_exp} : rx_new;

            assign o_dat[g] = dat_reg;
            assign o_dat_oe[g] = en & lane_tx[g];
            assign rxb_w[g*32 +: 32] = rxb_reg;

            always @(posedge i_mclk) begin
                if (i_srst) begin
                    sh_reg <= 32'h0000_0000;
                    txb_reg <= 32'h0000_0000;
                    rxb_reg <= 32'h0000_0000;
                    dat_reg <= 1'b0;
                end else begin
                    if (pop & (ld_sel == LANE)) begin
                        txb_reg <= tx_cooked;
                    end
                    // A lane whose word never arrived sends zeros
                    if (first_fall & lane_tx[g]) begin
                        sh_reg <= ld_pend_reg[g] ? 32'h0000_0000 : tx_al;
                        dat_reg <= ~ld_pend_reg[g] & (lsbf ? tx_al[0] : tx_al[31]);
                    end else if (fall_evt & active_reg & lane_tx[g]) begin
                        sh_reg <= lsbf ? (sh_reg >> 1) : (sh_reg << 1);
                        dat_reg <= lsbf ? sh_reg[1] : sh_reg[30];
                    end
                    if (rise_evt & active_reg & ~first_reg & ~lane_tx[g]) begin
                        sh_reg <= lsbf ? {rbit, sh_reg[31:1]} : {sh_reg[30:0], rbit};
                        if (last_bit) begin
                            rxb_reg <= rx_word;
                        end
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Stream buffers toward the memory channel
    // ----------------------------------------------------------------
    ssp_fifo #(
        .WIDTH(32),
        .DEPTH(`SSP_FIFO_DEPTH),
        .AW(`SSP_FIFO_AW)
    ) u_tx_fifo (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_wr_data(i_tx_data),
        .i_wr_valid(i_tx_valid),
        .o_wr_ready(o_tx_ready),
        .o_rd_data(tx_rd_data),
        .o_rd_valid(tx_rd_valid),
        .i_rd_ready(pop)
    );

    ssp_fifo #(
        .WIDTH(32),
        .DEPTH(`SSP_FIFO_DEPTH),
        .AW(`SSP_FIFO_AW)
    ) u_rx_fifo (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_wr_data(ps_sel ? rxb_w[63:32] : rxb_w[31:0]),
        .i_wr_valid(|push_pend_reg),
        .o_wr_ready(rx_wr_ready),
        .o_rd_data(o_rx_data),
        .o_rd_valid(o_rx_valid),
        .i_rd_ready(i_rx_ready)
    );
endmodule // ssp_top

// >>> shared/ssp_map.vh
// Register map, field positions, reset values and timing counts of the serial port unit
//
// Summary of operation
// - One clock, one sync, two lanes, each direction-selectable.
// - Bit clock never faster than half core clock.
// - TDM: ports 0,1 receive; ports 2,3 transmit.
// - I2S: two lanes carry two stereo channels.
// - Software picks MSB-first or LSB-first shifting.
// - Standard word length 3 to 32 bits.
// - I2S word length limited to 8..32 bits.
// - Framing options plus optional mu-law/A-law companding.
// - Clock and sync each internal or external.
// - Words stream to memory through dedicated channel.
`ifndef SSP_MAP_VH
`define SSP_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SSP_REG_CTRL 4'h0
`define SSP_REG_CLKDIV 4'h4
`define SSP_REG_STATUS 4'h8
`define SSP_REG_TDM 4'hC

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define SSP_CTL_EN 0
`define SSP_CTL_DIRA 1
`define SSP_CTL_DIRB 2
`define SSP_CTL_LSBF 3
`define SSP_CTL_ICLK 4
`define SSP_CTL_IFS 5
`define SSP_CTL_MODE_LO 6
`define SSP_CTL_MODE_HI 7
`define SSP_CTL_CMP_LO 8
`define SSP_CTL_CMP_HI 9
`define SSP_CTL_WLEN_LO 10
`define SSP_CTL_WLEN_HI 14
`define SSP_ST_OVF 0
`define SSP_ST_UNF 1

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define SSP_CTRL_RST 32'h0000_7C00
`define SSP_CLKDIV_RST 16'h0000
`define SSP_TDM_RST 5'h07
`define SSP_MODE_STD 2'h0
`define SSP_MODE_I2S 2'h1
`define SSP_MODE_TDM 2'h2
`define SSP_CMP_MU 2'h1
`define SSP_CMP_A 2'h2
`define SSP_WLEN_MIN_STD 6'h03
`define SSP_WLEN_MIN_I2S 6'h08
`define SSP_WLEN_FULL 6'h20

// ----------------------------------------------------------------
// Companding constants
// ----------------------------------------------------------------
`define SSP_MU_CLIP 16'h1FDE
`define SSP_MU_BIAS 16'h0021
`define SSP_MU_DBIAS 16'h0084
`define SSP_A_CLIP 16'h0FFF
`define SSP_A_XOR 8'h55

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSP_CLK_NS 25
`define SSP_MAX_RATE_MBPS 50
`define SSP_MIN_BIT_NS (1000 / `SSP_MAX_RATE_MBPS)
`define SSP_SCLK_MIN_HALF_CYC ((`SSP_MIN_BIT_NS / 2 + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`define SSP_FIFO_DEPTH 4
`define SSP_FIFO_AW 2

`endif

// >>> verilog/ssp_fifo.v
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps

module ssp_fifo #(
    parameter WIDTH = 32, // Word width
    parameter DEPTH = 4, // Entries, a power of two
    parameter AW = 2 // Index width, log2 of DEPTH
) (
    input wire i_mclk, // Core clock
    input wire i_srst, // Synchronous reset, active high
    input wire [WIDTH-1:0] i_wr_data, // Fill data
    input wire i_wr_valid, // Fill request
    output wire o_wr_ready, // Room available
    output wire [WIDTH-1:0] o_rd_data, // Head word
    output wire o_rd_valid, // Head word present
    input wire i_rd_ready // Drain accepts head
);
    localparam [AW:0] FULL = DEPTH[AW:0];

    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wp_reg;
    reg [AW-1:0] rp_reg;
    reg [AW:0] cnt_reg;
    wire wr;
    wire rd;

    assign o_wr_ready = (cnt_reg != FULL);
    assign o_rd_valid = (cnt_reg != {(AW+1){1'b0}});
    assign o_rd_data = mem_reg[rp_reg];
    assign wr = i_wr_valid & o_wr_ready;
    assign rd = o_rd_valid & i_rd_ready;

    always @(posedge i_mclk) begin
        if (wr) begin
            mem_reg[wp_reg] <= i_wr_data;
        end
    end

    // Pointers wrap by overflow, which is why DEPTH must be a power of two
    always @(posedge i_mclk) begin
        if (i_srst) begin
            wp_reg <= {AW{1'b0}};
            rp_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (wr) begin
                wp_reg <= wp_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (rd) begin
                rp_reg <= rp_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (wr & ~rd) begin
                cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
            end else if (rd & ~wr) begin
                cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // ssp_fifo

// >>> test/ssp_asserts.sv
// Concurrent checks on the serial port unit pins
`timescale 1ns/1ps
module ssp_asserts (
    input wire i_mclk, // clock
    input wire i_srst, // reset
    input wire [3:0] i_avs_address, // address
    input wire i_avs_read, // read
    input wire i_avs_write, // write
    input wire [31:0] o_avs_readdata, // rdata
    input wire o_avs_waitrequest, // stall
    input wire o_sclk_oe, // clock drive
    input wire o_fs_oe, // sync drive
    input wire [1:0] o_dat, // lanes
    input wire [1:0] o_dat_oe, // lane drive
    input wire o_tx_ready, // tx room
    input wire [31:0] o_rx_data, // rx word
    input wire o_rx_valid, // rx offered
    input wire i_rx_ready, // rx taken
    input wire o_frame_start // frame pulse
);
    // --------
    // Checks
    // --------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    sequence s_stall;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    wait_rise_a: assert property ($rose(i_avs_read || i_avs_write) |-> s_stall)
        else $error("no stall");
    wait_one_a: assert property (s_stall |=> !o_avs_waitrequest)
        else $error("stall length");
    wait_idle_a: assert property (!i_avs_read && !i_avs_write |-> !o_avs_waitrequest)
        else $error("idle stall");
    unmapped_zero_a: assert property (i_avs_read && !o_avs_waitrequest &&
        i_avs_address[1:0] != 2'h0 |-> o_avs_readdata == 32'h0) else $error("unmapped");
    reset_quiet_a: assert property ($fell(i_srst) |-> !o_sclk_oe && !o_fs_oe &&
        o_dat_oe == 2'h0 && o_tx_ready) else $error("reset state");
    pulse_one_a: assert property (o_frame_start |=> !o_frame_start)
        else $error("long pulse");
    rx_hold_a: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid &&
        $stable(o_rx_data)) else $error("rx dropped");
    lane_idle_a: assert property ((o_dat & ~o_dat_oe) == 2'h0)
        else $error("idle lane");
endmodule // ssp_asserts
bind ssp_top ssp_asserts ssp_asserts_inst (.*);

// >>> test/ssp_codec.sv
// Codec model: clocks one frame on request, sends a word, captures one
`timescale 1ns/1ps
module ssp_codec #(
    parameter HALF = 100, // Half bit period, ns
    parameter N = 16 // Word length
) (
    input wire i_go, // Start a frame
    input wire [31:0] i_word, // Word sent MSB first
    input wire i_lane, // Port transmit lane
    output reg o_sclk = 1'b0, // Bit clock, still between frames
    output reg o_fs = 1'b0, // Frame sync
    output reg o_dat = 1'b0, // Data to the port
    output reg [31:0] o_cap = 32'h0, // Captured word
    output reg o_done = 1'b0 // Frame over
);
    integer k;
    always @(posedge i_go) begin
        o_done = 1'b0;
        o_cap = 32'h0;
        o_fs = 1'b1;
        #HALF o_sclk = 1'b1;
        #HALF o_sclk = 1'b0;
        o_fs = 1'b0;
        for (k = N - 1; k >= 0; k = k - 1) begin
            o_dat = i_word[k];
            #HALF o_sclk = 1'b1;
            o_cap = {o_cap[30:0], i_lane};
            #HALF o_sclk = 1'b0;
        end
        // Released line must not keep its last value
        o_dat = ~o_dat;
        o_done = 1'b1;
    end
endmodule // ssp_codec

// >>> test/ssp_top_tb.sv
// Bench for the serial port unit against the codec model
`timescale 1ns/1ps
`include "ssp_map.vh"
`define CHK(n, e, s) begin checks = checks + 1; if ((s) !== (e)) begin failures = failures + 1; $display("wrong value %s exp %h got %h", n, e, s); end end
module ssp_top_tb;
    reg i_mclk = 1'b0, i_srst = 1'b1, rd = 1'b0, wr = 1'b0, go = 1'b0, rx_rdy = 1'b0, tv = 1'b0;
    reg [3:0] adr = 4'h0;
    reg [31:0] wd = 32'h0, td = 32'h0, q;
    integer failures = 0, checks = 0, cyc = 0, k;
    wire [31:0] rdat, rxd, cap;
    wire [1:0] dat, doe;
    wire wt, sck, sck_oe, fs, fs_oe, tx_rdy, rxv, c_sck, c_fs, c_dat, done;
    always #12.5 i_mclk = ~i_mclk;
    ssp_top ssp_top_inst (.i_mclk(i_mclk), .i_srst(i_srst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_sclk(sck_oe ? sck : c_sck),
        .o_sclk(sck), .o_sclk_oe(sck_oe), .i_fs(fs_oe ? fs : c_fs), .o_fs(fs), .o_fs_oe(fs_oe),
        .i_dat({c_dat, dat[0]}), .o_dat(dat), .o_dat_oe(doe), .i_tx_data(td), .i_tx_valid(tv),
        .o_tx_ready(tx_rdy), .o_rx_data(rxd), .o_rx_valid(rxv), .i_rx_ready(rx_rdy),
        .o_frame_start());
    ssp_codec ssp_codec_inst (.i_go(go), .i_word(32'h0000_1234), .i_lane(dat[0]),
        .o_sclk(c_sck), .o_fs(c_fs), .o_dat(c_dat), .o_cap(cap), .o_done(done));
    task av(input w, input [3:0] a, input [31:0] d);
        begin
            @(posedge i_mclk);
            {wr, rd, adr, wd} <= {w, !w, a, d};
            @(posedge i_mclk);
            while (wt !== 1'b0) @(posedge i_mclk);
            q = rdat;
            {wr, rd} <= 2'h0;
        end
    endtask
    task frame(input [31:0] e);
        begin
            go <= 1'b1;
            @(posedge done);
            `CHK("codec word", e, cap)
            go <= 1'b0;
            @(posedge i_mclk);
        end
    endtask
    task t_regs;
        begin
            av(1'b0, `SSP_REG_CTRL, 32'h0);
            `CHK("ctrl", `SSP_CTRL_RST, q)
            av(1'b0, `SSP_REG_TDM, 32'h0);
            `CHK("slots", 32'h7, q)
            av(1'b0, 4'h2, 32'h0);
            `CHK("unmapped", 32'h0, q)
        end
    endtask
    task t_fill;
        begin
            av(1'b1, `SSP_REG_CTRL, 32'h0000_3C03);
            for (k = 0; k < 4; k = k + 1) begin
                td <= (k == 0) ? 32'h0000_A5C3 : (k == 1) ? 32'h0000_1E01 : 32'h0;
                tv <= 1'b1;
                @(posedge i_mclk);
            end
            tv <= 1'b0;
            @(negedge i_mclk);
            `CHK("tx room", 1'b0, tx_rdy)
        end
    endtask
    task t_msb;
        begin
            frame(32'h0000_A5C3);
            while (rxv !== 1'b1) @(negedge i_mclk);
            `CHK("rx word", 32'h0000_1234, rxd)
            @(posedge i_mclk);
            rx_rdy <= 1'b1;
            @(posedge i_mclk);
            rx_rdy <= 1'b0;
        end
    endtask
    task t_lsb;
        begin
            av(1'b1, `SSP_REG_CTRL, 32'h0000_3C0B);
            frame(32'h0000_8078);
        end
    endtask
    task t_int;
        begin
            av(1'b1, `SSP_REG_CTRL, 32'h0000_3C33);
            @(negedge i_mclk) q[0] = sck;
            @(negedge i_mclk);
            `CHK("drives", {3'h7, !q[0]}, {sck_oe, fs_oe, doe[0], sck})
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    initial begin
        repeat (20) @(posedge i_mclk);
        i_srst <= 1'b0;
        t_regs;
        t_fill;
        t_msb;
        t_lsb;
        t_int;
        end_of_test;
    end
endmodule // ssp_top_tb
